// >>> rtl/brc_regs.vh
// register offsets, field positions and reset values of the bus release/control bank
// assumes: included by the bank module, APB byte addresses, 32-bit data
`ifndef BRC_REGS_VH
`define BRC_REGS_VH
// ==========================================
// offsets
`define BRC_RELEASE_OFS 12'h000
`define BRC_CYCLE_OFS 12'h004
// ==========================================
// release-control fields
`define BRC_A23_BIT 7
`define BRC_A22_BIT 6
`define BRC_A21_BIT 5
`define BRC_A20_BIT 4
`define BRC_BUS_RELEASE_ENABLE_BIT 0
`define BRC_RELEASE_RST_M12 8'hfe
`define BRC_RELEASE_RST_M34 8'hee
`define BRC_RELEASE_FIXED 8'h0e
// ==========================================
// cycle-control fields
`define BRC_IDLE_AREA_BIT 7
`define BRC_IDLE_RW_BIT 6
`define BRC_BROM_BIT 5
`define BRC_BLEN_BIT 4
`define BRC_BWORD_BIT 3
`define BRC_RSVD_BIT 2
`define BRC_DIV_BIT 1
`define BRC_WAIT_BIT 0
`define BRC_CYCLE_RST 8'hc6
`define BRC_CYCLE_FIXED 8'h04
// ==========================================
// burst figures
`define BRC_BURST_STATES_SHORT 2'h2
`define BRC_BURST_STATES_LONG 2'h3
`define BRC_BURST_WORDS_SHORT 4'h4
`define BRC_BURST_WORDS_LONG 4'h8
`endif

// >>> rtl/brc_bank.v
// bus release and bus cycle control register bank with APB slave
// assumes: i_mode static after reset, i_hw_standby synchronous to i_ref_clk
`include "brc_regs.vh"

// How it works
// R1 - release reg resets to fe in modes 1/2, ee in modes 3/4; kept in soft standby
// R2 - cycle reg resets to c6 on reset and hardware standby; kept in soft standby
// R3 - release bits 7..5 low route address 23..21 onto port A pins 4..6
// R4 - in modes 1 and 2 writes cannot change address enable bits 7..5
// R5 - address-20 enable read-only: 0 in modes 3/4, 1 in modes 1/2
// R6 - release bits 3..1 ignore writes and read as 1
// R7 - bus release granted only when release enable bit 0 is set
// R8 - cycle bit 7 set inserts idle between reads to different areas
// R9 - cycle bit 6 set inserts idle between a read and a following write
// R10 - cycle bit 5 selects burst ROM interface for area 0
// R11 - cycle bit 4 picks burst cycle of 2 or 3 states
// R12 - cycle bit 3 picks 4-word or 8-word burst limit
// R13 - cycle bit 2 reserved, ignores writes, reads as 1
// R14 - cycle bit 1 chooses equal 2 Mbyte areas or the uneven division
// R15 - area division select only effective in modes 3 and 4
// R16 - cycle bit 0 gates the external wait input
// R17 - static mode input sets reset values, write protection, division validity
module brc_bank (
   input wire i_ref_clk, // system clock
   input wire i_reset_n, // async chip reset, active low
   input wire i_hw_standby, // hardware standby, high = reinitialise
   input wire [2:0] i_mode, // operating mode 1..4
   input wire i_psel, // apb select
   input wire i_penable, // apb enable
   input wire i_pwrite, // apb direction
   input wire [11:0] i_paddr, // apb byte address
   input wire [31:0] i_pwdata, // apb write data
   output wire o_pready, // apb ready
   output reg [31:0] o_prdata, // apb read data
   output wire o_pslverr, // apb error on unmapped address
   input wire i_wait_n, // external wait pin, active low
   input wire i_bus_req_n, // external bus request pin, active low
   input wire i_prev_read, // previous external cycle was a read
   input wire [2:0] i_prev_area, // area of previous external cycle
   input wire i_next_read, // next external cycle is a read
   input wire [2:0] i_next_area, // area of next external cycle
   output wire [3:0] o_addr_pin_sel, // a23..a20 on pa4..pa7 when high
   output wire o_bus_grant, // bus released to external master
   output wire o_idle_insert, // one idle state before next cycle
   output wire o_area0_burst_rom, // area 0 uses burst rom interface
   output wire [1:0] o_burst_states, // states per burst access cycle
   output wire [3:0] o_burst_words, // max words per burst
   output wire o_area_div_uneven, // uneven area division in effect
   output wire o_wait_active // wait requested and honoured
);

   // ==========================================
   // mode decode
   function is_mode34;
      input [2:0] mode;
      begin
         is_mode34 = (mode == 3'h3) || (mode == 3'h4);
      end
   endfunction

   wire mode34 = is_mode34(i_mode); // R17

   // ==========================================
   // pin synchronisers
   reg [1:0] wait_sync_ff;
   reg [1:0] external_bus_request_sync_ff;
   always @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wait_sync_ff <= 2'h3;
         external_bus_request_sync_ff <= 2'h3;
      end else begin
         wait_sync_ff <= {wait_sync_ff[0], i_wait_n};
         external_bus_request_sync_ff <= {external_bus_request_sync_ff[0], i_bus_req_n};
      end
   end

   // ==========================================
   // apb decode
   wire hit_rel = (i_paddr == `BRC_RELEASE_OFS);
   wire hit_cyc = (i_paddr == `BRC_CYCLE_OFS);
   wire access = i_psel && i_penable;
   wire wr_rel = access && i_pwrite && hit_rel;
   wire wr_cyc = access && i_pwrite && hit_cyc;
   assign o_pready = 1'b1;
   assign o_pslverr = access && !(hit_rel || hit_cyc);

   // ==========================================
   // registers
   reg [3:0] addr_en_n_ff; // bits 7..5 stored, 4 derived
   reg bus_release_enable_ff;
   reg [7:0] cyc_ff;
   reg init_done_ff;
   reg [2:0] nxt_addr_en;
   reg [7:0] nxt_cyc;
   // mode-dependent reset pattern, sliced on purpose below
   wire [7:0] rel_rst = mode34 ? `BRC_RELEASE_RST_M34 : `BRC_RELEASE_RST_M12; // R1 R17

   always @* begin
      nxt_addr_en = addr_en_n_ff[3:1];
      if (wr_rel && mode34) begin
         nxt_addr_en = i_pwdata[`BRC_A23_BIT:`BRC_A21_BIT]; // R3 R4
      end
      nxt_cyc = cyc_ff;
      if (wr_cyc) begin
         nxt_cyc = i_pwdata[7:0] | `BRC_CYCLE_FIXED; // R13
      end
   end

   // mode-dependent reset caught on first clock after release
   always @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         addr_en_n_ff <= 4'hf;
         bus_release_enable_ff <= 1'b0;
         cyc_ff <= `BRC_CYCLE_RST; // R2
         init_done_ff <= 1'b0;
      end else if (!init_done_ff || i_hw_standby) begin
         init_done_ff <= 1'b1;
         addr_en_n_ff <= rel_rst[7:4]; // R1
         bus_release_enable_ff <= rel_rst[`BRC_BUS_RELEASE_ENABLE_BIT]; // R1
         cyc_ff <= `BRC_CYCLE_RST; // R2
      end else begin
         addr_en_n_ff <= {nxt_addr_en, ~mode34}; // R5
         if (wr_rel) begin
            bus_release_enable_ff <= i_pwdata[`BRC_BUS_RELEASE_ENABLE_BIT];
         end
         cyc_ff <= nxt_cyc;
      end
   end

   wire [7:0] rel_val = {addr_en_n_ff, 3'h7, bus_release_enable_ff}; // R6

   // ==========================================
   // read data
   always @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_prdata <= 32'h0;
      end else if (i_psel && !i_penable && !i_pwrite) begin
         o_prdata <= hit_rel ? {24'h0, rel_val} : hit_cyc ? {24'h0, cyc_ff} : 32'h0;
      end
   end

   // ==========================================
   // block controls
   assign o_addr_pin_sel = ~addr_en_n_ff; // R3 R5
   assign o_bus_grant = bus_release_enable_ff && !external_bus_request_sync_ff[1]; // R7
   assign o_idle_insert = i_prev_read &&
      ((cyc_ff[`BRC_IDLE_AREA_BIT] && i_next_read && (i_prev_area != i_next_area)) || // R8
       (cyc_ff[`BRC_IDLE_RW_BIT] && !i_next_read)); // R9
   assign o_area0_burst_rom = cyc_ff[`BRC_BROM_BIT]; // R10
   assign o_burst_states = cyc_ff[`BRC_BLEN_BIT] ?
      `BRC_BURST_STATES_LONG : `BRC_BURST_STATES_SHORT; // R11
   assign o_burst_words = cyc_ff[`BRC_BWORD_BIT] ?
      `BRC_BURST_WORDS_LONG : `BRC_BURST_WORDS_SHORT; // R12
   assign o_area_div_uneven = mode34 && !cyc_ff[`BRC_DIV_BIT]; // R14 R15
   assign o_wait_active = cyc_ff[`BRC_WAIT_BIT] && !wait_sync_ff[1]; // R16

endmodule // brc_bank

// >>> test/brc_bank_asserts.sv
// port checker for the bus release/cycle control bank
// assumes: bound to brc_bank, mode static while out of reset
module brc_bank_asserts (
   input wire i_ref_clk, i_reset_n, i_hw_standby, i_wait_n, i_bus_req_n, // control pins
   input wire i_prev_read, i_next_read, o_bus_grant, o_idle_insert, // cycle info
   input wire o_area0_burst_rom, o_area_div_uneven, o_wait_active, // decoded fields
   input wire [2:0] i_mode, // operating mode
   input wire [3:0] o_addr_pin_sel, o_burst_words, // pin selects, burst depth
   input wire [1:0] o_burst_states // burst cycle length
);
   timeunit 1ns;
   timeprecision 1ns;
   wire m34 = i_mode > 3'h2;
   // ==========================================
   // properties
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);
   a_grant_req: assert property (o_bus_grant |-> !$past(i_bus_req_n, 2))
      else $error("grant without request");
   a_wait_pin: assert property (o_wait_active |-> !$past(i_wait_n, 2))
      else $error("wait without pin");
   a_pins_low: assert property (!m34 |-> o_addr_pin_sel == 4'h0)
      else $error("address pin in mode 1/2");
   a_a20_fixed: assert property ($past(i_reset_n) |-> o_addr_pin_sel[0] == m34)
      else $error("address 20 select wrong");
   a_states_val: assert property (o_burst_states == 2'h2 || o_burst_states == 2'h3)
      else $error("burst states");
   a_words_val: assert property (o_burst_words == 4'h4 || o_burst_words == 4'h8)
      else $error("burst words");
   a_div_low: assert property (!m34 |-> !o_area_div_uneven)
      else $error("division in mode 1/2");
   a_stby_init: assert property ($past(i_hw_standby) |-> o_addr_pin_sel == {3'h0, m34}
      && !o_area0_burst_rom && o_burst_states == 2'h2 && o_burst_words == 4'h4
      && !o_wait_active && !o_area_div_uneven && !o_bus_grant) else $error("standby init");
   a_idle_rw: assert property ($past(i_hw_standby) && i_prev_read && !i_next_read |-> o_idle_insert)
      else $error("no idle after read");
   cover property (o_bus_grant);
   cover property (o_wait_active);
   cover property (o_area_div_uneven);
endmodule // brc_bank_asserts
bind brc_bank brc_bank_asserts brc_bank_asserts_i (.*);

// >>> test/brc_bank_tb.sv
// self-checking bench for brc_bank, random register traffic per mode
// assumes: pready answers in the access phase, registers at 0x000 and 0x004
module brc_bank_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_ref_clk, i_reset_n, i_hw_standby, i_psel, i_penable, i_pwrite, i_wait_n, i_bus_req_n;
   logic i_prev_read, i_next_read;
   logic [2:0] i_mode, i_prev_area, i_next_area;
   logic [11:0] i_paddr;
   logic [31:0] i_pwdata;
   wire o_pready, o_pslverr, o_bus_grant, o_idle_insert, o_area0_burst_rom;
   wire o_area_div_uneven, o_wait_active;
   wire [31:0] o_prdata;
   wire [3:0] o_addr_pin_sel, o_burst_words;
   wire [1:0] o_burst_states;
   logic [7:0] rel, cyc;
   int fail_count, compares;
   brc_bank brc_bank_i (.*);
   initial begin
      i_ref_clk = 0;
      forever #20 i_ref_clk = ~i_ref_clk;
   end
   // ==========================================
   // checking and bus tasks
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task results;
      $display("mismatches %0d compares %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
      int n;
      @(posedge i_ref_clk);
      i_psel <= 1; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
      @(posedge i_ref_clk);
      i_penable <= 1;
      n = 0;
      do begin @(posedge i_ref_clk); n++; end while (o_pready !== 1'b1 && n < 20);
      if (n >= 20) begin fail_count++; results; end
      r = o_prdata; e = o_pslverr;
      i_psel <= 0; i_penable <= 0;
   endtask
   task outs;
      logic [31:0] r;
      logic e;
      apb(0, 12'h000, 0, r, e); chk(r, {24'h0, rel});
      apb(0, 12'h004, 0, r, e); chk(r, {24'h0, cyc});
      chk({~rel[7:4]}, o_addr_pin_sel);
      chk(o_burst_states, cyc[4] ? 2'h3 : 2'h2);
      chk(o_burst_words, cyc[3] ? 4'h8 : 4'h4);
      chk(o_area0_burst_rom, cyc[5]);
      chk(o_area_div_uneven, i_mode > 2 && !cyc[1]);
      chk(o_wait_active, cyc[0] && !i_wait_n);
      chk(o_bus_grant, rel[0] && !i_bus_req_n);
      chk(o_idle_insert, (cyc[7] && i_prev_read && i_next_read && i_prev_area != i_next_area)
          || (cyc[6] && i_prev_read && !i_next_read));
   endtask
   function logic [7:0] rst_rel();
      return (i_mode > 2) ? 8'hee : 8'hfe;
   endfunction
   // ==========================================
   // main sequence
   initial begin
      logic [31:0] r, d;
      logic e;
      {i_reset_n, i_hw_standby, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = 0;
      {i_wait_n, i_bus_req_n, i_prev_read, i_next_read, i_prev_area, i_next_area} = 10'h300;
      i_mode = 1; fail_count = 0; compares = 0;
      void'($urandom(76580));
      for (int m = 1; m < 5; m++) begin
         i_reset_n <= 0; i_mode <= m;
         repeat (8) @(posedge i_ref_clk);
         i_reset_n <= 1;
         @(posedge i_ref_clk);
         rel = rst_rel(); cyc = 8'hc6;
         outs;
         for (int k = 0; k < 12; k++) begin
            d = (k == 0) ? 0 : (k == 1) ? 32'hffffffff : $urandom;
            {i_wait_n, i_bus_req_n, i_prev_read, i_next_read, i_prev_area, i_next_area} <= $urandom;
            apb(1, 12'h000, d, r, e);
            rel = (i_mode > 2) ? {d[7:5], 4'h7, d[0]} : {7'h7f, d[0]};
            apb(1, 12'h004, ~d, r, e);
            cyc = ~d[7:0] | 8'h04;
            outs;
         end
         apb(1, 12'h008, 0, r, e); chk(e, 1'b1);
         apb(0, 12'h008, 0, r, e); chk(r, 0);
         i_hw_standby <= 1; i_prev_read <= 1; i_next_read <= 0;
         @(posedge i_ref_clk);
         i_hw_standby <= 0;
         rel = rst_rel(); cyc = 8'hc6;
         outs;
      end
      results;
   end
endmodule // brc_bank_tb
